// ---- logic/vgacr_regs.vh ----
// register offsets, field positions and reset values of the scan and address block
// assumes the includer works in the character clock domain
`ifndef VGACR_REGS_VH
`define VGACR_REGS_VH

`define VGACR_IDX_VAEND       8'h12
`define VGACR_IDX_PITCH       8'h13
`define VGACR_IDX_ULMODE      8'h14

`define VGACR_OVF_VAEND_B8    1
`define VGACR_OVF_VAEND_B9    6
`define VGACR_UL_RSVD         7
`define VGACR_UL_DWORD        6
`define VGACR_UL_CNT4         5
`define VGACR_MODE_BYTE       6
`define VGACR_MODE_DIV2       3
`define VGACR_CLK_DWORD       4

`define VGACR_RST_BYTE        8'h00
`define VGACR_UL_WMASK        8'h7F

`define VGACR_ADDR_WORD       3'h1
`define VGACR_ADDR_BYTE       3'h2
`define VGACR_ADDR_DWORD      3'h4

// advance interval minus one, as fed to the pacing divider
`define VGACR_DIV_1           2'h0
`define VGACR_DIV_2           2'h1
`define VGACR_DIV_4           2'h3

`endif

// ---- logic/vgacr_step_gen.v ----
// address counter advance pacing: one pulse every 1, 2 or 4 character clocks
// assumes a synchronous active-low reset copy from the top module
`timescale 1ns/1ns
module vgacr_step_gen #(
    parameter DIV_W = 2
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstSync_n,
    // pacing select
    input  wire             run,
    input  wire [DIV_W-1:0] divSel,
    // advance pulse
    output reg              stepPulse_ff
);
    reg  [DIV_W-1:0] phase_ff;
    reg  [DIV_W-1:0] nxt_phase;
    reg              nxt_step;

    always @* begin
        nxt_phase = {DIV_W{1'b0}};
        nxt_step  = 1'b0;
        if (run) begin
            if (phase_ff >= divSel) begin
                nxt_step = 1'b1;
            end else begin
                nxt_phase = phase_ff + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            phase_ff     <= {DIV_W{1'b0}};
            stepPulse_ff <= 1'b0;
        end else begin
            phase_ff     <= nxt_phase;
            stepPulse_ff <= nxt_step;
        end
    end
endmodule

// ---- logic/vgacr_scan_addr.v ----
// indexed crt controller registers for active-end line, row pitch and address modes
// assumes index/data strobes are synchronous to the character clock clk
`timescale 1ns/1ns
`include "vgacr_regs.vh"

// Functional notes
// - the active-end line number is 10 bits, low 8 from vertical_active_end_low.
// - its top two bits come from overflow bits 6 (bit 9) and 1 (bit 8).
// - row_pitch holds the whole 8-bit row offset used as each row's memory pitch.
// - the row offset counts words or doublewords per the clocking mode register.
// - bit 7 of underline_and_addr_mode is reserved and reads as zero.
// - doubleword addressing bit set forces doubleword addressing.
// - with it clear, crt mode bit 6 picks word (0) or byte (1) addressing.
// - count-by-four clear advances the counter every 1 or 2 character clocks.
// - count-by-four set advances it every 4 or 2 clocks per crt mode bit 3.
module vgacr_scan_addr (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // crt controller data port
    input  wire [7:0] crIndex,
    input  wire       crWrite,
    input  wire       crRead,
    input  wire [7:0] crWrData,
    output reg  [7:0] crRdData_ff,
    output reg        crRdHit_ff,
    // neighbouring registers held elsewhere
    input  wire [7:0] timing_overflow_reg,
    input  wire [7:0] crt_mode_control_reg,
    input  wire [7:0] clocking_mode_reg,
    // scan timing
    input  wire       scanRun,
    output reg  [9:0] activeEndLine_ff,
    output reg  [9:0] rowPitchUnits_ff,
    // frame buffer address control
    output reg  [2:0] addrMode_ff,
    output reg  [1:0] advanceDiv_ff,
    output reg        addrAdvance_ff
);
    reg        rstMeta_ff;
    reg        rstSync_ff;
    reg  [7:0] vaEndLow_ff;
    reg  [7:0] rowPitch_ff;
    reg  [7:0] ulMode_ff;
    reg  [7:0] nxt_rdData;
    reg        nxt_rdHit;
    reg  [2:0] nxt_addrMode;
    reg  [1:0] nxt_div;
    reg  [9:0] nxt_pitch;
    wire       dwordBit;
    wire       cnt4Bit;
    wire       stepPulse;

    // reset released through two flops so deassertion is clean
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    assign dwordBit = ulMode_ff[`VGACR_UL_DWORD];
    assign cnt4Bit  = ulMode_ff[`VGACR_UL_CNT4];

    // register writes
    always @(posedge clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            vaEndLow_ff <= `VGACR_RST_BYTE;
            rowPitch_ff <= `VGACR_RST_BYTE;
            ulMode_ff   <= `VGACR_RST_BYTE;
        end else if (crWrite) begin
            case (crIndex)
                `VGACR_IDX_VAEND: begin
                    vaEndLow_ff <= crWrData;
                end
                `VGACR_IDX_PITCH: begin
                    rowPitch_ff <= crWrData;
                end
                `VGACR_IDX_ULMODE: begin
                    ulMode_ff <= crWrData & `VGACR_UL_WMASK;
                end
                default: begin
                    ulMode_ff <= ulMode_ff;
                end
            endcase
        end
    end

    // read mux; other indices belong to other blocks, so no hit
    always @* begin
        nxt_rdData = 8'h00;
        nxt_rdHit  = 1'b0;
        if (crRead) begin
            case (crIndex)
                `VGACR_IDX_VAEND: begin
                    nxt_rdData = vaEndLow_ff;
                    nxt_rdHit  = 1'b1;
                end
                `VGACR_IDX_PITCH: begin
                    nxt_rdData = rowPitch_ff;
                    nxt_rdHit  = 1'b1;
                end
                `VGACR_IDX_ULMODE: begin
                    nxt_rdData = {1'b0, ulMode_ff[6:0]};
                    nxt_rdHit  = 1'b1;
                end
                default: begin
                    nxt_rdData = 8'h00;
                    nxt_rdHit  = 1'b0;
                end
            endcase
        end
    end

    // addressing mode and pacing decode
    always @* begin
        if (dwordBit) begin
            nxt_addrMode = `VGACR_ADDR_DWORD;
        end else if (crt_mode_control_reg[`VGACR_MODE_BYTE]) begin
            nxt_addrMode = `VGACR_ADDR_BYTE;
        end else begin
            nxt_addrMode = `VGACR_ADDR_WORD;
        end
        // divider value is interval minus one
        if (cnt4Bit) begin
            nxt_div = crt_mode_control_reg[`VGACR_MODE_DIV2] ? `VGACR_DIV_2 : `VGACR_DIV_4;
        end else begin
            nxt_div = crt_mode_control_reg[`VGACR_MODE_DIV2] ? `VGACR_DIV_2 : `VGACR_DIV_1;
        end
        // pitch in bytes: words are two, doublewords four
        if (clocking_mode_reg[`VGACR_CLK_DWORD]) begin
            nxt_pitch = {rowPitch_ff, 2'h0};
        end else begin
            nxt_pitch = {1'b0, rowPitch_ff, 1'b0};
        end
    end

    always @(posedge clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            crRdData_ff      <= 8'h00;
            crRdHit_ff       <= 1'b0;
            activeEndLine_ff <= 10'h000;
            rowPitchUnits_ff <= 10'h000;
            addrMode_ff      <= `VGACR_ADDR_WORD;
            advanceDiv_ff    <= `VGACR_DIV_1;
            addrAdvance_ff   <= 1'b0;
        end else begin
            crRdData_ff      <= nxt_rdData;
            crRdHit_ff       <= nxt_rdHit;
            activeEndLine_ff <= {timing_overflow_reg[`VGACR_OVF_VAEND_B9],
                                 timing_overflow_reg[`VGACR_OVF_VAEND_B8],
                                 vaEndLow_ff};
            rowPitchUnits_ff <= nxt_pitch;
            addrMode_ff      <= nxt_addrMode;
            advanceDiv_ff    <= nxt_div;
            addrAdvance_ff   <= stepPulse;
        end
    end

    vgacr_step_gen #(
        .DIV_W (2)
    ) i_vgacr_step_gen (
        .clk          (clk),
        .rstSync_n    (rstSync_ff),
        .run          (scanRun),
        .divSel       (advanceDiv_ff),
        .stepPulse_ff (stepPulse)
    );
endmodule

// ---- bench/vgacr_scan_chk.sv ----
// assertions on the ports of the scan and address block
// assumes one character clock and the async low reset rst_n
`timescale 1ns/1ns
module vgacr_scan_chk (
    // clock and reset
    input wire       clk,
    input wire       rst_n,
    // register port
    input wire [7:0] crIndex,
    input wire       crWrite,
    input wire       crRead,
    input wire [7:0] crWrData,
    input wire [7:0] crRdData_ff,
    input wire       crRdHit_ff,
    // neighbours and derived outputs
    input wire [7:0] crt_mode_control_reg,
    input wire [7:0] timing_overflow_reg,
    input wire [7:0] clocking_mode_reg,
    input wire [9:0] activeEndLine_ff,
    input wire [9:0] rowPitchUnits_ff,
    input wire [2:0] addrMode_ff,
    input wire [1:0] advanceDiv_ff,
    input wire       addrAdvance_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // outputs lag the release by the two sync flops
    reg  [1:0] age_ff;
    wire       settled = (age_ff == 2'h3);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            age_ff <= 2'h0;
        else if (!settled)
            age_ff <= age_ff + 2'h1;
    end
    sequence wrQuiet(idx);
        settled && crWrite && crIndex == idx ##1 !crWrite [*2];
    endsequence
    a_end_low_byte: assert property (wrQuiet(8'h12) |-> activeEndLine_ff[7:0] == $past(crWrData, 2))
        else $error("active end low byte wrong");
    a_end_high_bits: assert property (settled |=> activeEndLine_ff[9:8] ==
        {$past(timing_overflow_reg[6]), $past(timing_overflow_reg[1])})
        else $error("active end high bits wrong");
    a_pitch_scaled: assert property (
        wrQuiet(8'h13) |-> rowPitchUnits_ff ==
        ({2'h0, $past(crWrData, 2)} << (clocking_mode_reg[4] ? 2 : 1)))
        else $error("row pitch wrong");
    a_dword_force: assert property (
        wrQuiet(8'h14) ##0 ($past(crWrData, 2) & 8'h40) != 8'h00
        |-> addrMode_ff == 3'h4)
        else $error("doubleword_addressing_bit not forced");
    a_word_byte: assert property (
        wrQuiet(8'h14) ##0 ($past(crWrData, 2) & 8'h40) == 8'h00
        |-> addrMode_ff == (crt_mode_control_reg[6] ? 3'h2 : 3'h1))
        else $error("word or byte mode wrong");
    a_adv_interval: assert property (
        wrQuiet(8'h14) |-> advanceDiv_ff == (crt_mode_control_reg[3]
        ? 2'h1 : (($past(crWrData, 2) & 8'h20) != 8'h00 ? 2'h3 : 2'h0)))
        else $error("advance interval wrong");
    a_pulse_gap: assert property (
        (advanceDiv_ff == 2'h3) [*5] ##0 addrAdvance_ff
        |=> (!addrAdvance_ff || advanceDiv_ff != 2'h3) [*3])
        else $error("advance pulses too close");
    a_read_msb_zero: assert property (settled && crRead && crIndex == 8'h14
        |=> crRdHit_ff && !crRdData_ff[7])
        else $error("reserved bit read not zero");
    a_read_unmapped: assert property (settled && crRead && (crIndex < 8'h12 || crIndex > 8'h14)
        |=> !crRdHit_ff && crRdData_ff == 8'h00)
        else $error("unmapped read answered");
endmodule
bind vgacr_scan_addr vgacr_scan_chk i_vgacr_scan_chk (.*);

// ---- bench/tb_vgacr_scan_addr.sv ----
// bench for the scan and address block
// assumes a 10 MHz character clock and inputs driven 1 ns after each edge
`timescale 1ns/1ns
module tb_vgacr_scan_addr;
    reg        clk = 1'b0, rst_n = 1'b0, crWrite = 1'b0, crRead = 1'b0, scanRun = 1'b0;
    reg  [7:0] crIndex = 8'h00, crWrData = 8'h00, timing_overflow_reg = 8'h00;
    reg  [7:0] crt_mode_control_reg = 8'h00, clocking_mode_reg = 8'h00, wd;
    wire [7:0] crRdData_ff;
    wire       crRdHit_ff, addrAdvance_ff;
    wire [9:0] activeEndLine_ff, rowPitchUnits_ff;
    wire [2:0] addrMode_ff;
    wire [1:0] advanceDiv_ff;
    reg  [9:0] gap;
    integer    n_mismatch = 0, n_compared = 0, i;
    vgacr_scan_addr i_vgacr_scan_addr (.*);
    initial forever #50 clk = ~clk;
    task chk(input [9:0] seen, input [9:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task step(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        crIndex = idx;
        crWrData = d;
        crWrite = 1'b1;
        step(1);
        crWrite = 1'b0;
    endtask
    // expected value is {hit, data}
    task rd(input [7:0] idx, input [9:0] exp);
        crIndex = idx;
        crRead = 1'b1;
        step(1);
        crRead = 1'b0;
        chk({1'b0, crRdHit_ff, crRdData_ff}, exp);
    endtask
    // cycles up to the next advance pulse, 9 means none came
    task pw;
        gap = 10'h000;
        do begin
            step(1);
            gap = gap + 10'h001;
        end while (!addrAdvance_ff && gap < 10'h009);
    endtask
    task end_sim;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
    initial begin
        step(3);
        rst_n = 1'b1;
        step(3);
        scanRun = 1'b1;
        timing_overflow_reg = 8'h42;
        wr(8'h12, 8'h5A);
        step(2);
        chk(activeEndLine_ff, 10'h35A);
        timing_overflow_reg = 8'h02;
        step(3);
        chk(activeEndLine_ff, 10'h15A);
        rd(8'h12, 10'h15A);
        // 480 active lines: the last one is numbered 479
        wr(8'h12, 8'hDF);
        step(2);
        chk(activeEndLine_ff, 10'h1DF);
        wr(8'h13, 8'hFF);
        step(2);
        chk(rowPitchUnits_ff, 10'h1FE);
        clocking_mode_reg = 8'h10;
        step(3);
        chk(rowPitchUnits_ff, 10'h3FC);
        rd(8'h15, 10'h000);
        for (i = 0; i < 8; i = i + 1) begin
            crt_mode_control_reg = {1'b0, i[0], 2'h0, i[0], 3'h0};
            wd = {1'b1, i[2], i[1], 5'h0A};
            wr(8'h14, wd);
            step(2);
            chk({7'h00, addrMode_ff}, i[2] ? 10'h004 : (i[0] ? 10'h002 : 10'h001));
            chk({8'h00, advanceDiv_ff}, i[0] ? 10'h001 : (i[1] ? 10'h003 : 10'h000));
            rd(8'h14, {2'h1, wd & 8'h7F});
            pw;
            pw;
            pw;
            chk(gap, i[0] ? 10'h002 : (i[1] ? 10'h004 : 10'h001));
        end
        scanRun = 1'b0;
        step(4);
        pw;
        chk(gap, 10'h009);
        // second reset with scanRun low; byte mode is still selected outside
        rst_n = 1'b0;
        step(1);
        rst_n = 1'b1;
        step(3);
        chk({7'h00, addrMode_ff}, 10'h002);
        rd(8'h14, 10'h100);
        rd(8'h13, 10'h100);
        end_sim;
    end
endmodule
